// ### hdl/config_register_crc_guard.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module config_register_crc_guard (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_NVM_FAULT,
  output logic O_DRIVE_ENABLE_PIN,
  output logic O_IRQ
);
  import cfg_guard_pkg::*;

  logic rst_s1_q, rst_n;
  logic [1:0] fault_sync_q;
  logic [7:0] function_config_q, revision_reg_q, powerdown_threshold_cfg_q, err_cfg_q;
  logic [7:0] token_feedback_q, window_two_cfg_q, window_one_cfg_q, pulse_low_q;
  logic [7:0] device_config_two_q, device_config_one_q, exp_sig_q;
  logic check_en_q, nvm_check_start_q, lock_q, diag_q, drive_q, safe_q;
  logic cfg_err_q, nvm_signature_error_q, crc_busy_q;
  logic [7:0] crc_q;
  logic [2:0] byte_idx_q;
  logic [12:0] nvm_cnt_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
  logic cfg_trapped_q;
  logic wr, rd_ok, mapped, prot_wr, ctrl_wr, en_set, en_clr;
  logic [63:0] guard_word;
  logic [31:0] rdata_d;

  // One byte through the divider, most significant bit first
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Reset takes effect at once but is released on the clock
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      fault_sync_q <= 2'b00;
    end else begin
      fault_sync_q <= {fault_sync_q[0], I_NVM_FAULT};
    end
  end

  // Zero-wait APB slave
  assign O_PREADY = 1'b1;
  assign wr = I_PSEL & I_PENABLE & I_PWRITE;
  always_comb begin
    mapped = 1'b1;
    rdata_d = 32'h0;
    unique case (I_PADDR)
      ADDR_FUNC_CFG: rdata_d[7:0] = function_config_q;
      ADDR_REVISION: rdata_d[7:0] = revision_reg_q;
      ADDR_PWD_THR: rdata_d[7:0] = powerdown_threshold_cfg_q;
      ADDR_ERR_CFG: rdata_d[7:0] = err_cfg_q;
      ADDR_TOKEN_FB: rdata_d[7:0] = token_feedback_q;
      ADDR_WIN2: rdata_d[7:0] = window_two_cfg_q;
      ADDR_WIN1: rdata_d[7:0] = window_one_cfg_q;
      ADDR_PULSE_LOW: rdata_d[7:0] = pulse_low_q;
      ADDR_DEVICE_CONFIG_TWO: rdata_d[7:0] = device_config_two_q;
      ADDR_DEVICE_CONFIG_ONE: rdata_d[7:0] = device_config_one_q;
      ADDR_EXP_SIG: rdata_d[7:0] = exp_sig_q;
      ADDR_CTRL: rdata_d[4:0] = {drive_q, diag_q, lock_q, nvm_check_start_q, check_en_q};
      ADDR_STATUS: rdata_d[3:0] = {crc_busy_q, safe_q, nvm_signature_error_q, cfg_err_q};
      ADDR_IRQ_STAT: rdata_d[IRQ_W-1:0] = irq_stat_q;
      ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
      default: mapped = 1'b0;
    endcase
  end
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
  assign rd_ok = I_PSEL & ~I_PENABLE & ~I_PWRITE;

  // Read data registered in setup so it is stable in access
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_PRDATA <= 32'h0;
    end else if (rd_ok) begin
      O_PRDATA <= rdata_d;
    end
  end

  // Lock covers configuration and expected signature, never the control word
  assign prot_wr = wr & ~lock_q & (I_PADDR <= ADDR_EXP_SIG);
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      function_config_q <= BYTE_RESET;
      revision_reg_q <= REV_RESET;
      powerdown_threshold_cfg_q <= BYTE_RESET;
      err_cfg_q <= BYTE_RESET;
      token_feedback_q <= BYTE_RESET;
      window_two_cfg_q <= BYTE_RESET;
      window_one_cfg_q <= BYTE_RESET;
      pulse_low_q <= BYTE_RESET;
      device_config_two_q <= BYTE_RESET;
      device_config_one_q <= BYTE_RESET;
      exp_sig_q <= BYTE_RESET;
    end else if (prot_wr) begin
      unique case (I_PADDR)
        ADDR_FUNC_CFG: function_config_q <= I_PWDATA[7:0];
        ADDR_PWD_THR: powerdown_threshold_cfg_q <= I_PWDATA[7:0];
        ADDR_ERR_CFG: err_cfg_q <= I_PWDATA[7:0];
        ADDR_TOKEN_FB: token_feedback_q <= I_PWDATA[7:0];
        ADDR_WIN2: window_two_cfg_q <= I_PWDATA[7:0];
        ADDR_WIN1: window_one_cfg_q <= I_PWDATA[7:0];
        ADDR_PULSE_LOW: pulse_low_q <= I_PWDATA[7:0];
        ADDR_DEVICE_CONFIG_TWO: device_config_two_q <= I_PWDATA[7:0];
        ADDR_DEVICE_CONFIG_ONE: device_config_one_q <= I_PWDATA[7:0];
        ADDR_EXP_SIG: exp_sig_q <= I_PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // Revision is read-only; it still feeds the guard word
  assign guard_word = {function_config_q[6:0], revision_reg_q, powerdown_threshold_cfg_q[3:0],
                       err_cfg_q, token_feedback_q, window_two_cfg_q[4:0], window_one_cfg_q[6:0],
                       pulse_low_q, device_config_two_q, device_config_one_q[6]};

  // Only a change of enable from 0 to 1 starts a check
  assign ctrl_wr = wr & (I_PADDR == ADDR_CTRL);
  assign en_set = ctrl_wr & I_PWDATA[CTRL_CHECK_EN] & ~check_en_q;
  assign en_clr = ctrl_wr & ~I_PWDATA[CTRL_CHECK_EN] & check_en_q;

  // Lock clears only by software write of zero or reset
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
      diag_q <= 1'b1;
      drive_q <= 1'b0;
    end else if (ctrl_wr) begin
      lock_q <= I_PWDATA[CTRL_LOCK];
      diag_q <= I_PWDATA[CTRL_DIAG];
      drive_q <= I_PWDATA[CTRL_DRIVE];
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      check_en_q <= 1'b0;
    end else if (en_clr & cfg_err_q & diag_q) begin
      check_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      check_en_q <= I_PWDATA[CTRL_CHECK_EN];
    end
  end

  // Signature engine: one byte per cycle, eight cycles
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      crc_busy_q <= 1'b0;
      crc_q <= CRC_SEED;
      byte_idx_q <= 3'h0;
    end else if (en_set) begin
      crc_busy_q <= 1'b1;
      crc_q <= CRC_SEED;
      byte_idx_q <= 3'h0;
    end else if (crc_busy_q) begin
      crc_q <= crc8_byte(crc_q, guard_word[{byte_idx_q, 3'b000} +: 8]);
      byte_idx_q <= byte_idx_q + 3'h1;
      if (byte_idx_q == 3'(CRC_BYTES - 1)) begin
        crc_busy_q <= 1'b0;
      end
    end
  end

  // Memory check timer and self-clearing start bit
  // Thirteen bits span the full check time at this clock
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      nvm_check_start_q <= 1'b0;
      nvm_cnt_q <= 13'h0;
    end else if (nvm_check_start_q) begin
      nvm_cnt_q <= nvm_cnt_q + 13'h1;
      if (nvm_cnt_q == 13'(NVM_CHECK_CYCLES - 1)) begin
        nvm_check_start_q <= 1'b0;
      end
    end else if (ctrl_wr & I_PWDATA[CTRL_NVM_START]) begin
      nvm_check_start_q <= 1'b1;
      nvm_cnt_q <= 13'h0;
    end
  end

  // Last byte of the signature and last cycle of the memory check
  logic crc_done, nvm_done, nvm_good;
  assign crc_done = crc_busy_q & (byte_idx_q == 3'(CRC_BYTES - 1));
  assign nvm_done = nvm_check_start_q & (nvm_cnt_q == 13'(NVM_CHECK_CYCLES - 1));
  // Enable dropped with a pending error poisons the next memory check
  assign nvm_good = ~fault_sync_q[1] & ~cfg_trapped_q;

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_trapped_q <= 1'b0;
    end else if (en_clr & cfg_err_q) begin
      cfg_trapped_q <= 1'b1;
    end else if (en_set | nvm_done) begin
      cfg_trapped_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_err_q <= 1'b0;
    // A finished signature outranks a memory result in the same cycle
    end else if (crc_done) begin
      cfg_err_q <= crc8_byte(crc_q, guard_word[63:56]) != exp_sig_q;
    end else if (nvm_done & nvm_good) begin
      cfg_err_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      nvm_signature_error_q <= 1'b0;
    end else if (en_clr & cfg_err_q & diag_q) begin
      nvm_signature_error_q <= 1'b1;
    // Completion decides the flag before the running level holds it
    end else if (nvm_done) begin
      nvm_signature_error_q <= ~nvm_good;
    end else if (nvm_check_start_q) begin
      nvm_signature_error_q <= 1'b1;
    end
  end

  // Safe state is left only by reset
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      safe_q <= 1'b0;
    end else if (en_clr & cfg_err_q & diag_q) begin
      safe_q <= 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_DRIVE_ENABLE_PIN <= 1'b0;
    end else begin
      // Safe state overrides the drive bit
      O_DRIVE_ENABLE_PIN <= drive_q & ~safe_q;
    end
  end

  assign irq_ev = {en_clr & cfg_err_q & diag_q, nvm_done, crc_done & (crc8_byte(crc_q, guard_word[63:56]) != exp_sig_q),
                   crc_done};
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      // A new event wins over a simultaneous clear
      irq_stat_q <= (irq_stat_q & ~((wr && I_PADDR == ADDR_IRQ_STAT) ? I_PWDATA[IRQ_W-1:0] : '0)) | irq_ev;
      if (wr && I_PADDR == ADDR_IRQ_MASK) begin
        irq_mask_q <= I_PWDATA[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_IRQ <= 1'b0;
    end else begin
      // Level follows the status one cycle late
      O_IRQ <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

// ### pkg/cfg_guard_pkg.sv
package cfg_guard_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'hff;
  localparam int unsigned CRC_BYTES = 8;
  // Memory check duration
  localparam int unsigned NVM_CHECK_US = 811;
  localparam int unsigned NVM_CHECK_CYCLES = NVM_CHECK_US * (CLK_HZ / 1_000_000);
  // Register byte addresses
  localparam logic [7:0] ADDR_FUNC_CFG = 8'h00;
  localparam logic [7:0] ADDR_REVISION = 8'h04;
  localparam logic [7:0] ADDR_PWD_THR = 8'h08;
  localparam logic [7:0] ADDR_ERR_CFG = 8'h0c;
  localparam logic [7:0] ADDR_TOKEN_FB = 8'h10;
  localparam logic [7:0] ADDR_WIN2 = 8'h14;
  localparam logic [7:0] ADDR_WIN1 = 8'h18;
  localparam logic [7:0] ADDR_PULSE_LOW = 8'h1c;
  localparam logic [7:0] ADDR_DEVICE_CONFIG_TWO = 8'h20;
  localparam logic [7:0] ADDR_DEVICE_CONFIG_ONE = 8'h24;
  localparam logic [7:0] ADDR_EXP_SIG = 8'h28;
  localparam logic [7:0] ADDR_CTRL = 8'h2c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h34;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h38;
  // Control bits
  localparam int unsigned CTRL_CHECK_EN = 0;
  localparam int unsigned CTRL_NVM_START = 1;
  localparam int unsigned CTRL_LOCK = 2;
  localparam int unsigned CTRL_DIAG = 3;
  localparam int unsigned CTRL_DRIVE = 4;
  // Status bits
  localparam int unsigned ST_CFG_ERR = 0;
  localparam int unsigned ST_NVM_ERR = 1;
  localparam int unsigned ST_SAFE = 2;
  localparam int unsigned ST_BUSY = 3;
  // Interrupt events: check done, cfg error, nvm done, safe entry
  localparam int unsigned IRQ_W = 4;
  localparam logic [7:0] REV_RESET = 8'h01; // Arbitrary value
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// ### verif/config_register_crc_guard_bench.sv
`timescale 1ns/1ps
`default_nettype none
module config_register_crc_guard_bench;
  import cfg_guard_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, fault = 0, serr;
  logic [7:0] paddr = '0, sig;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, drive, irq;
  logic [7:0] cfg [0:9];
  integer seed = 64690, err_count = 0, n_checks = 0, i, k;
  config_register_crc_guard dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_NVM_FAULT(fault), .O_DRIVE_ENABLE_PIN(drive), .O_IRQ(irq));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic finish_test;
    $display("mismatches %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bail;
    err_count++;
    finish_test();
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; the idle cycle after it keeps each strobe to one assignment per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 8) bail();
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Polls the self-clearing start bit; the bound covers the full check time
  task automatic nvm_wait;
    int n;
    apb(0, ADDR_CTRL, 0);
    for (n = 0; n < 3000 && rd[CTRL_NVM_START] !== 1'b0; n++) apb(0, ADDR_CTRL, 0);
    if (n == 3000) bail();
  endtask
  function automatic logic [7:0] crc_of(input logic [63:0] w);
    logic [7:0] c;
    c = CRC_SEED;
    for (int b = 0; b < 64; b++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[8 * (b / 8) + 7 - b % 8]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  function automatic logic [63:0] word_of();
    return {cfg[0][6:0], REV_RESET, cfg[2][3:0], cfg[3], cfg[4], cfg[5][4:0], cfg[6][6:0], cfg[7], cfg[8], cfg[9][6]};
  endfunction
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h8);
    chk(crc_of(64'h0), 8'hdb);
    apb(1, ADDR_REVISION, 32'h5a);
    apb(0, ADDR_REVISION, 0);
    chk(rd, REV_RESET);
    apb(0, 8'h3c, 0);
    chk({serr, rd}, {1'b1, 32'h0});
    apb(1, ADDR_IRQ_MASK, 32'hf);
    for (i = 0; i < 4; i++) begin
      for (k = 0; k < 10; k++) begin
        cfg[k] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
        if (k != 1) apb(1, 8'(4 * k), {24'h0, cfg[k]});
      end
      // Odd passes store a signature one bit off
      sig = crc_of(word_of()) ^ {7'h0, i[0]};
      apb(1, ADDR_EXP_SIG, {24'h0, sig});
      apb(1, ADDR_CTRL, 32'h18);
      apb(1, ADDR_CTRL, 32'h19);
      repeat (21) @(posedge clk);
      apb(0, ADDR_STATUS, 0);
      chk(rd, {32'h0, i[0]});
      chk(drive, 1);
      if (i[0]) begin
        apb(1, ADDR_CTRL, 32'h1b);
        apb(0, ADDR_STATUS, 0);
        chk(rd[ST_NVM_ERR], 1);
        nvm_wait();
        apb(1, ADDR_CTRL, 32'h18);
        apb(0, ADDR_STATUS, 0);
        chk(rd[1:0], 0);
      end
    end
    apb(1, ADDR_CTRL, 32'h18);
    apb(1, ADDR_CTRL, 32'h1d);
    repeat (21) @(posedge clk);
    apb(1, ADDR_EXP_SIG, {24'h0, ~sig});
    apb(0, ADDR_EXP_SIG, 0);
    chk(rd, sig);
    apb(1, ADDR_CTRL, 32'h19);
    apb(1, ADDR_CTRL, 32'h18);
    repeat (4) @(posedge clk);
    apb(0, ADDR_STATUS, 0);
    chk(rd[2:1], 2'b11);
    apb(0, ADDR_CTRL, 0);
    chk(rd[CTRL_CHECK_EN], 0);
    chk({drive, irq}, 2'b01);
    apb(1, ADDR_IRQ_MASK, 0);
    @(posedge clk);
    chk(irq, 0);
    apb(1, ADDR_IRQ_STAT, 32'hf);
    apb(1, ADDR_IRQ_MASK, 32'hf);
    apb(0, ADDR_IRQ_STAT, 0);
    chk({irq, rd}, 33'h0);
    // Enable dropped over a pending error spoils a later memory check
    apb(1, ADDR_CTRL, 32'h2);
    nvm_wait();
    apb(0, ADDR_STATUS, 0);
    chk(rd[1:0], 2'b11);
    // A bad memory result keeps both flags set
    apb(1, ADDR_CTRL, 32'h1);
    fault <= 1'b1;
    apb(1, ADDR_CTRL, 32'h3);
    nvm_wait();
    apb(0, ADDR_STATUS, 0);
    chk(rd[1:0], 2'b11);
    finish_test();
  end
endmodule
`default_nettype wire

// ### verif/guard_properties.sv
`timescale 1ns/1ps
`default_nettype none
module guard_properties (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_IRQ
);
  import cfg_guard_pkg::*;
  logic acc;
  logic wr;
  logic [3:0] mask_q;
  logic [13:0] run_q;
  assign acc = I_PSEL && I_PENABLE;
  assign wr = acc && I_PWRITE;
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) mask_q <= '0;
    else if (wr && I_PADDR == ADDR_IRQ_MASK) mask_q <= I_PWDATA[3:0];
  end
  // Cycles since the memory check was launched, saturating
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) run_q <= '0;
    else if (wr && I_PADDR == ADDR_CTRL && I_PWDATA[CTRL_NVM_START]) run_q <= 14'h1;
    else if (run_q != 14'h0 && run_q != 14'h2328) run_q <= run_q + 14'h1;
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_rd(logic [7:0] a);
    acc && !I_PWRITE && I_PADDR == a;
  endsequence
  a_ready_access: assert property (acc |-> O_PREADY) else $error("pready low in access");
  a_unmapped_err: assert property (acc && I_PADDR > ADDR_IRQ_MASK |-> O_PSLVERR) else $error("no slave error");
  a_unmapped_zero: assert property (acc && !I_PWRITE && I_PADDR > ADDR_IRQ_MASK |-> O_PRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (acc && !I_PWRITE |-> O_PRDATA[31:8] == 24'h0) else $error("upper bits set");
  a_revision_fixed: assert property (s_rd(ADDR_REVISION) |-> O_PRDATA[7:0] == REV_RESET)
    else $error("revision changed");
  a_irq_masked: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !O_IRQ) else $error("irq while masked");
  a_start_held: assert property (s_rd(ADDR_CTRL) ##0 (run_q > 2 && run_q < 8100) |-> O_PRDATA[CTRL_NVM_START])
    else $error("start bit dropped early");
  a_start_clears: assert property (s_rd(ADDR_CTRL) ##0 run_q > 8120 |-> !O_PRDATA[CTRL_NVM_START])
    else $error("start bit stuck");
  a_nvm_flag_held: assert property (s_rd(ADDR_STATUS) ##0 (run_q > 2 && run_q < 8100) |-> O_PRDATA[ST_NVM_ERR])
    else $error("memory flag low while running");
endmodule
bind config_register_crc_guard guard_properties u_props (.I_CLOCK, .I_RESET_N, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_IRQ);
`default_nettype wire
